// *** core/sebl_cfg.svh ***
`ifndef SEBL_CFG_SVH
`define SEBL_CFG_SVH
`define SEBL_DW 32
`define SEBL_PAW 12
// serial channel and memory controller addresses on the system bus
`define SEBL_SER_FIFO_ADDR 32'hB000_0010
`define SEBL_SER_STAT_ADDR 32'hB000_0008
`define SEBL_RX_WORD_READY_BIT 11
`define SEBL_RX_FIFO_BYTE_COUNT_LSB 20
`define SEBL_RX_FIFO_BYTE_COUNT_MSB 21
`define SEBL_RX_FIFO_BYTE_COUNT_FULL 2'h0
`define SEBL_MC_ENTRY_BASE 32'hA070_0100
`define SEBL_DCTL_ADDR 32'hA070_0020
`define SEBL_DCFG0_ADDR 32'hA070_0100
`define SEBL_DCTL_BASE 32'h0000_0000
`define SEBL_DCTL_I_LSB 7
`define SEBL_DCTL_I_MSB 8
`define SEBL_I_NORMAL 2'h0
`define SEBL_I_MODE 2'h1
`define SEBL_PRECHARGE_ALL_CMD 2'h2
`define SEBL_BUF_BIT 19
`define SEBL_MEM_BASE 32'h0000_0000
// word counter values
`define SEBL_W_DISCARD 32'h0000_0001
`define SEBL_W_NUM 32'h0000_0002
`define SEBL_W_SDCFG 32'h0000_0003
`define SEBL_W_MC_FIRST 32'h0000_0004
`define SEBL_W_MC_LAST 32'h0000_0014
`define SEBL_W_PRECHARGE 32'h0000_0015
`define SEBL_W_MODE 32'h0000_0021
`define SEBL_W_CODE_FIRST 32'h0000_0022
// sequencing counts
`define SEBL_FIRST_NOPS 3'h7
`define SEBL_LOOP_NOPS 3'h4
`define SEBL_BATCH 3'h4
`define SEBL_SETTLE 2'h3
// register reset values
`define SEBL_CMD_RST 32'h0300_0000
`define SEBL_NOP_RST 32'h0000_0000
// APB offsets and status fields
`define SEBL_A_CMD 12'h000
`define SEBL_A_NOP 12'h004
`define SEBL_A_STATUS 12'h008
`define SEBL_A_COUNT 12'h00C
`define SEBL_ST_DONE_BIT 0
`define SEBL_ST_BOOT_BIT 1
`define SEBL_ST_WCNT_LSB 16
`endif

// *** core/sebl_pkg.sv ***
`include "sebl_cfg.svh"
package sebl_pkg;
	typedef enum logic [4:0] {
		ST_STRAP, ST_BYPASS, ST_CMD, ST_FILL, ST_POLL, ST_READ, ST_ACT, ST_NEXT,
		ST_MC_WR, ST_PRECHARGE, ST_MODE, ST_MODE_RD, ST_NORMAL, ST_CFG_RD, ST_CFG_WR,
		ST_MEM_WR, ST_DONE
	} sebl_state_t;

	typedef struct packed {
		logic req;
		logic write;
		logic [`SEBL_DW-1:0] addr;
		logic [`SEBL_DW-1:0] wdata;
	} sebl_bus_req_t;

	typedef struct packed {
		sebl_bus_req_t bus;
		logic done;
		logic [`SEBL_DW-1:0] rdata;
	} sebl_bm_t;

	typedef struct packed {
		sebl_state_t state;
		logic [1:0] strap_s1;
		logic [1:0] strap_s2;
		logic [1:0] settle;
		logic [2:0] fill;
		logic [2:0] batch;
		logic pend;
		logic go;
		sebl_bus_req_t op;
		logic [`SEBL_DW-1:0] wcnt;
		logic [`SEBL_DW-1:0] num;
		logic [`SEBL_DW-1:0] sdcfg;
		logic [`SEBL_DW-1:0] word;
		logic cpu_rst;
		logic ser_rst;
		logic booting;
		logic [`SEBL_DW-1:0] cmd_word;
		logic [`SEBL_DW-1:0] nop_word;
		logic [`SEBL_DW-1:0] prdata;
	} sebl_core_t;
endpackage : sebl_pkg

// *** core/sebl_bus_master.sv ***
`timescale 1ns/1ps
`include "sebl_cfg.svh"
module sebl_bus_master (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// command side
	input wire logic i_go,
	input sebl_pkg::sebl_bus_req_t i_op,
	output logic o_done,
	output logic [`SEBL_DW-1:0] o_rdata,
	// system bus side
	output sebl_pkg::sebl_bus_req_t o_bus,
	input wire logic i_ack,
	input wire logic [`SEBL_DW-1:0] i_rdata
);
	import sebl_pkg::*;

	sebl_bm_t cur;
	sebl_bm_t nxt;

	// one access at a time; a go while busy cannot occur, the core waits for done
	always_comb begin
		nxt = cur;
		nxt.done = 1'b0;
		if (!cur.bus.req && i_go) begin
			nxt.bus = i_op;
			nxt.bus.req = 1'b1;
		end else if (cur.bus.req && i_ack) begin
			nxt.bus.req = 1'b0;
			nxt.done = 1'b1;
			nxt.rdata = i_rdata;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			cur <= '0;
		end else begin
			cur <= nxt;
		end
	end

	assign o_bus = cur.bus;
	assign o_done = cur.done;
	assign o_rdata = cur.rdata;
endmodule : sebl_bus_master

// *** core/sebl_loader.sv ***
// Local design decisions: the address map and the APB register port.
`timescale 1ns/1ps
`include "sebl_cfg.svh"
module sebl_loader (
	// clock and reset
	input wire logic I_CORE_CLK,
	input wire logic I_RST,
	// boot strap pins
	input wire logic [1:0] I_BOOT_CFG,
	// reset controls
	output logic O_CPU_RST,
	output logic O_SER_RST,
	output logic O_BOOT_DONE,
	// system bus master
	output sebl_pkg::sebl_bus_req_t O_BUS,
	input wire logic I_BUS_ACK,
	input wire logic [`SEBL_DW-1:0] I_BUS_RDATA,
	// APB slave
	input wire logic I_PSEL,
	input wire logic I_PENABLE,
	input wire logic I_PWRITE,
	input wire logic [`SEBL_PAW-1:0] I_PADDR,
	input wire logic [`SEBL_DW-1:0] I_PWDATA,
	output logic [`SEBL_DW-1:0] O_PRDATA,
	output logic O_PREADY,
	output logic O_PSLVERR
);
	import sebl_pkg::*;

	sebl_core_t cur;
	sebl_core_t nxt;
	logic bm_done;
	logic [`SEBL_DW-1:0] bm_rdata;

	function automatic sebl_bus_req_t bus_op(input logic wr, input logic [`SEBL_DW-1:0] addr,
			input logic [`SEBL_DW-1:0] data);
		sebl_bus_req_t r;
		r.req = 1'b1;
		r.write = wr;
		r.addr = addr;
		r.wdata = data;
		return r;
	endfunction : bus_op

	// init command field placed into an otherwise fixed control word
	function automatic logic [`SEBL_DW-1:0] dctl_word(input logic [1:0] cmd);
		logic [`SEBL_DW-1:0] w;
		w = `SEBL_DCTL_BASE;
		w[`SEBL_DCTL_I_MSB:`SEBL_DCTL_I_LSB] = cmd;
		return w;
	endfunction : dctl_word

	function automatic logic word_ready(input logic [`SEBL_DW-1:0] stat);
		logic [1:0] rx_fifo_byte_count;
		rx_fifo_byte_count = stat[`SEBL_RX_FIFO_BYTE_COUNT_MSB:`SEBL_RX_FIFO_BYTE_COUNT_LSB];
		// a part word stays in the fifo until its last byte is in
		return stat[`SEBL_RX_WORD_READY_BIT] &&
			(rx_fifo_byte_count == `SEBL_RX_FIFO_BYTE_COUNT_FULL);
	endfunction : word_ready

	// both straps high select the serial boot; anything else runs the processor at once
	function automatic logic strap_boot(input logic [1:0] s);
		return &s;
	endfunction : strap_boot

	// an operation counts as finished only in the cycle of its own done pulse
	function automatic logic op_finished(input logic pend, input logic done);
		return pend && done;
	endfunction : op_finished

	// memory-controller entries sit one word apart, the first dynamic config first
	function automatic logic [`SEBL_DW-1:0] mc_entry_addr(input logic [`SEBL_DW-1:0] n);
		logic [`SEBL_DW-1:0] idx;
		idx = n - `SEBL_W_MC_FIRST;
		return `SEBL_MC_ENTRY_BASE + {idx[`SEBL_DW-3:0], 2'h0};
	endfunction : mc_entry_addr

	// boot code lands word by word from the bottom of system memory
	function automatic logic [`SEBL_DW-1:0] code_addr(input logic [`SEBL_DW-1:0] n);
		logic [`SEBL_DW-1:0] idx;
		idx = n - `SEBL_W_CODE_FIRST;
		return `SEBL_MEM_BASE + {idx[`SEBL_DW-3:0], 2'h0};
	endfunction : code_addr

	// end only once the header is consumed, so a stale count cannot stop early
	function automatic logic image_end(input logic [`SEBL_DW-1:0] n,
			input logic [`SEBL_DW-1:0] total);
		return (n >= `SEBL_W_MODE) && (n >= total);
	endfunction : image_end

	// a register write lands on the access edge of a transfer to its offset
	function automatic logic apb_write_hit(input logic sel, input logic en, input logic wr,
			input logic [`SEBL_PAW-1:0] a, input logic [`SEBL_PAW-1:0] off);
		return sel && en && wr && (a == off);
	endfunction : apb_write_hit

	function automatic logic in_done(input sebl_state_t st);
		return st == ST_DONE;
	endfunction : in_done

	function automatic logic is_mapped(input logic [`SEBL_PAW-1:0] a);
		return (a == `SEBL_A_CMD) || (a == `SEBL_A_NOP) || (a == `SEBL_A_STATUS) ||
			(a == `SEBL_A_COUNT);
	endfunction : is_mapped

	function automatic logic [`SEBL_DW-1:0] read_mux(input sebl_core_t s,
			input logic [`SEBL_PAW-1:0] a);
		logic [`SEBL_DW-1:0] d;
		d = '0;
		case (a)
			`SEBL_A_CMD: begin
				d = s.cmd_word;
			end
			`SEBL_A_NOP: begin
				d = s.nop_word;
			end
			`SEBL_A_STATUS: begin
				d[`SEBL_ST_DONE_BIT] = in_done(s.state);
				d[`SEBL_ST_BOOT_BIT] = s.booting;
				d[`SEBL_DW-1:`SEBL_ST_WCNT_LSB] = s.wcnt[`SEBL_DW-`SEBL_ST_WCNT_LSB-1:0];
			end
			`SEBL_A_COUNT: begin
				d = s.num;
			end
			default: begin
				d = '0;
			end
		endcase
		return d;
	endfunction : read_mux

	// one bus master serves every access, so no two can ever overlap
	sebl_bus_master i_sebl_bus_master (
		.i_clk(I_CORE_CLK),
		.i_rst(I_RST),
		.i_go(cur.go),
		.i_op(cur.op),
		.o_done(bm_done),
		.o_rdata(bm_rdata),
		.o_bus(O_BUS),
		.i_ack(I_BUS_ACK),
		.i_rdata(I_BUS_RDATA)
	);

	always_comb begin
		logic use_bus;
		sebl_bus_req_t op;
		sebl_state_t after;
		use_bus = 1'b0;
		op = '0;
		after = cur.state;
		nxt = cur;
		nxt.go = 1'b0;
		// straps are pins: two flops before anything looks at them
		nxt.strap_s1 = I_BOOT_CFG;
		nxt.strap_s2 = cur.strap_s1;

		// APB: reads latched in setup, writes land on the access edge
		if (I_PSEL && !I_PENABLE) begin
			nxt.prdata = read_mux(cur, I_PADDR);
		end
		if (apb_write_hit(I_PSEL, I_PENABLE, I_PWRITE, I_PADDR, `SEBL_A_CMD)) begin
			nxt.cmd_word = I_PWDATA;
		end
		if (apb_write_hit(I_PSEL, I_PENABLE, I_PWRITE, I_PADDR, `SEBL_A_NOP)) begin
			nxt.nop_word = I_PWDATA;
		end

		case (cur.state)
			ST_STRAP: begin
				// wait for the synchroniser to fill before judging the straps
				if (cur.settle != `SEBL_SETTLE) begin
					nxt.settle = cur.settle + 2'h1;
				end else if (strap_boot(cur.strap_s2)) begin
					nxt.cpu_rst = 1'b1;
					nxt.booting = 1'b1;
					nxt.state = ST_CMD;
				end else begin
					nxt.cpu_rst = 1'b0;
					nxt.state = ST_BYPASS;
				end
			end
			ST_BYPASS: begin
				// only a new reset can start a boot from here
				nxt.cpu_rst = 1'b0;
			end
			ST_CMD: begin
				use_bus = 1'b1;
				// the command word is writable, so other EEPROM sizes need no new logic
				op = bus_op(1'b1, `SEBL_SER_FIFO_ADDR, cur.cmd_word);
				after = ST_FILL;
				nxt.fill = `SEBL_FIRST_NOPS;
			end
			ST_FILL: begin
				use_bus = 1'b1;
				op = bus_op(1'b1, `SEBL_SER_FIFO_ADDR, cur.nop_word);
				after = (cur.fill == 3'h1) ? ST_POLL : ST_FILL;
				if (op_finished(cur.pend, bm_done)) begin
					nxt.fill = cur.fill - 3'h1;
				end
			end
			ST_POLL: begin
				use_bus = 1'b1;
				// status is read afresh each time; a stale ready must never admit a read
				op = bus_op(1'b0, `SEBL_SER_STAT_ADDR, '0);
				after = word_ready(bm_rdata) ? ST_READ : ST_POLL;
			end
			ST_READ: begin
				use_bus = 1'b1;
				op = bus_op(1'b0, `SEBL_SER_FIFO_ADDR, '0);
				after = ST_ACT;
				// the counter moves with the word, so each action sees its own number
				if (op_finished(cur.pend, bm_done)) begin
					nxt.word = bm_rdata;
					nxt.wcnt = cur.wcnt + 32'h1;
					nxt.batch = cur.batch + 3'h1;
				end
			end
			ST_ACT: begin
				if (cur.wcnt == `SEBL_W_DISCARD) begin
					nxt.state = ST_NEXT;
				end else if (cur.wcnt == `SEBL_W_NUM) begin
					nxt.num = cur.word;
					nxt.state = ST_NEXT;
				end else if (cur.wcnt == `SEBL_W_SDCFG) begin
					nxt.sdcfg = cur.word;
					nxt.state = ST_NEXT;
				end else if (cur.wcnt <= `SEBL_W_MC_LAST) begin
					nxt.state = ST_MC_WR;
				end else if (cur.wcnt == `SEBL_W_PRECHARGE) begin
					nxt.state = ST_PRECHARGE;
				end else if (cur.wcnt < `SEBL_W_MODE) begin
					nxt.state = ST_NEXT;
				end else if (cur.wcnt == `SEBL_W_MODE) begin
					nxt.state = ST_MODE;
				end else begin
					nxt.state = ST_MEM_WR;
				end
			end
			ST_MC_WR: begin
				use_bus = 1'b1;
				// each entry is its own single write, finished before the next word
				op = bus_op(1'b1, mc_entry_addr(cur.wcnt), cur.word);
				after = ST_NEXT;
			end
			ST_PRECHARGE: begin
				use_bus = 1'b1;
				// refresh may run while the discarded words stream in
				op = bus_op(1'b1, `SEBL_DCTL_ADDR, dctl_word(`SEBL_PRECHARGE_ALL_CMD));
				after = ST_NEXT;
			end
			ST_MODE: begin
				use_bus = 1'b1;
				op = bus_op(1'b1, `SEBL_DCTL_ADDR, dctl_word(`SEBL_I_MODE));
				after = ST_MODE_RD;
			end
			ST_MODE_RD: begin
				use_bus = 1'b1;
				// the read itself loads the mode; its data are not wanted
				op = bus_op(1'b0, cur.sdcfg, '0);
				after = ST_NORMAL;
			end
			ST_NORMAL: begin
				use_bus = 1'b1;
				// normal mode comes before the buffers, never the other way round
				op = bus_op(1'b1, `SEBL_DCTL_ADDR, dctl_word(`SEBL_I_NORMAL));
				after = ST_CFG_RD;
			end
			ST_CFG_RD: begin
				use_bus = 1'b1;
				op = bus_op(1'b0, `SEBL_DCFG0_ADDR, '0);
				after = ST_CFG_WR;
				if (op_finished(cur.pend, bm_done)) begin
					nxt.word = bm_rdata;
				end
			end
			ST_CFG_WR: begin
				use_bus = 1'b1;
				// buffer enable is forced here, whatever the image held
				op = bus_op(1'b1, `SEBL_DCFG0_ADDR, cur.word | (32'h1 << `SEBL_BUF_BIT));
				after = ST_NEXT;
			end
			ST_MEM_WR: begin
				use_bus = 1'b1;
				// addresses grow from zero; nothing stops an oversized image from wrapping
				op = bus_op(1'b1, code_addr(cur.wcnt), cur.word);
				after = ST_NEXT;
			end
			ST_NEXT: begin
				if (image_end(cur.wcnt, cur.num)) begin
					nxt.state = ST_DONE;
				end else if (cur.batch == `SEBL_BATCH) begin
					nxt.batch = 3'h0;
					nxt.fill = `SEBL_LOOP_NOPS;
					nxt.state = ST_FILL;
				end else begin
					nxt.state = ST_POLL;
				end
			end
			ST_DONE: begin
				// final state: only a reset leaves it, so the serial channel stays quiet
				nxt.cpu_rst = 1'b0;
				nxt.ser_rst = 1'b1;
				nxt.booting = 1'b0;
			end
			default: begin
				nxt.state = ST_STRAP;
			end
		endcase

		// shared handshake with the bus master: issue once, move on at done
		if (use_bus) begin
			if (!cur.pend) begin
				nxt.go = 1'b1;
				nxt.op = op;
				nxt.pend = 1'b1;
			end else if (op_finished(cur.pend, bm_done)) begin
				nxt.pend = 1'b0;
				nxt.state = after;
			end
		end
	end

	always_ff @(posedge I_CORE_CLK) begin
		if (I_RST) begin
			cur <= '0;
			cur.state <= ST_STRAP;
			// processor held from power-on until the straps are judged
			cur.cpu_rst <= 1'b1;
			cur.cmd_word <= `SEBL_CMD_RST;
			cur.nop_word <= `SEBL_NOP_RST;
		end else begin
			cur <= nxt;
		end
	end

	assign O_CPU_RST = cur.cpu_rst;
	assign O_SER_RST = cur.ser_rst;
	assign O_BOOT_DONE = in_done(cur.state);
	assign O_PRDATA = cur.prdata;
	// registers answer at once: no wait states
	assign O_PREADY = 1'b1;
	assign O_PSLVERR = I_PSEL && I_PENABLE && !is_mapped(I_PADDR);
endmodule : sebl_loader

// *** dv/sebl_loader_chk.sv ***
`timescale 1ns/1ps
`include "sebl_cfg.svh"
module sebl_loader_chk (
	// watched ports
	input wire logic I_CORE_CLK,
	input wire logic I_RST,
	input wire logic O_CPU_RST,
	input wire logic O_SER_RST,
	input wire logic O_BOOT_DONE,
	input sebl_pkg::sebl_bus_req_t O_BUS,
	input wire logic I_BUS_ACK,
	input wire logic [`SEBL_DW-1:0] I_BUS_RDATA
);
	import sebl_pkg::*;
	logic rdy;
	logic rd_ack;
	assign rd_ack = O_BUS.req && I_BUS_ACK && !O_BUS.write;
	// a fifo word may be taken only after a status read showed a whole word
	always_ff @(posedge I_CORE_CLK) begin
		if (I_RST) begin
			rdy <= 1'b0;
		end else if (rd_ack && O_BUS.addr == `SEBL_SER_STAT_ADDR) begin
			rdy <= I_BUS_RDATA[`SEBL_RX_WORD_READY_BIT] &&
				I_BUS_RDATA[`SEBL_RX_FIFO_BYTE_COUNT_MSB:`SEBL_RX_FIFO_BYTE_COUNT_LSB] ==
				`SEBL_RX_FIFO_BYTE_COUNT_FULL;
		end else if (rd_ack && O_BUS.addr == `SEBL_SER_FIFO_ADDR) begin
			rdy <= 1'b0;
		end
	end
	default clocking @(posedge I_CORE_CLK); endclocking
	default disable iff (I_RST);
	a_cpu_held: assert property (O_BUS.req |-> O_CPU_RST)
		else $error("bus access while cpu runs");
	a_quiet_bypass: assert property (!O_CPU_RST && !O_BOOT_DONE |-> !O_BUS.req && !O_SER_RST)
		else $error("activity without boot");
	a_serial_only: assert property (O_BUS.req && O_BUS.addr[31:24] == 8'hB0
		|-> O_BUS.addr == `SEBL_SER_FIFO_ADDR || O_BUS.addr == `SEBL_SER_STAT_ADDR)
		else $error("wrong serial address");
	a_read_ready: assert property (rd_ack && O_BUS.addr == `SEBL_SER_FIFO_ADDR |-> rdy)
		else $error("fifo read without ready word");
	a_req_hold: assert property (O_BUS.req && !I_BUS_ACK |=> O_BUS.req && $stable(O_BUS))
		else $error("request changed before ack");
	a_one_access: assert property (O_BUS.req && I_BUS_ACK |=> !O_BUS.req)
		else $error("request kept after ack");
	a_ser_order: assert property ($rose(O_SER_RST) |-> !O_CPU_RST && O_BOOT_DONE)
		else $error("serial reset before cpu release");
	a_done_final: assert property (O_BOOT_DONE |-> ##2 O_BOOT_DONE && O_SER_RST && !O_CPU_RST)
		else $error("done state not final");
	a_bus_after: assert property (O_SER_RST |-> !O_BUS.req)
		else $error("bus access after boot");
endmodule : sebl_loader_chk
bind sebl_loader sebl_loader_chk i_sebl_loader_chk (
	.I_CORE_CLK(I_CORE_CLK),
	.I_RST(I_RST),
	.O_CPU_RST(O_CPU_RST),
	.O_SER_RST(O_SER_RST),
	.O_BOOT_DONE(O_BOOT_DONE),
	.O_BUS(O_BUS),
	.I_BUS_ACK(I_BUS_ACK),
	.I_BUS_RDATA(I_BUS_RDATA)
);

// *** dv/sebl_bus_model.sv ***
`timescale 1ns/1ps
`include "sebl_cfg.svh"
module sebl_bus_model (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// system bus slave
	input sebl_pkg::sebl_bus_req_t i_bus,
	output logic o_ack,
	output logic [`SEBL_DW-1:0] o_rdata
);
	import sebl_pkg::*;
	logic [31:0] img [0:63];
	logic [31:0] mc [0:16];
	logic [31:0] mem [0:31];
	logic [31:0] first_tx, mode_addr, st;
	logic [1:0] ctl [$];
	int rx, rd, dly, ops, memw;
	always @(posedge i_clk) begin
		o_ack <= 1'b0;
		// released data never repeats the last word
		o_rdata <= ~o_rdata;
		if (i_rst) begin
			o_rdata <= '0;
			rx = 0;
			rd = 0;
			dly = 0;
			ops = 0;
			memw = 0;
			first_tx = '0;
			mode_addr = '0;
			ctl.delete();
		end else if (i_bus.req && !o_ack && dly > 0) begin
			dly--;
		end else if (i_bus.req && !o_ack) begin
			o_ack <= 1'b1;
			ops++;
			// mix of prompt and slow answers
			dly = (ops * 7) % 4;
			if (i_bus.write) begin
				if (i_bus.addr == `SEBL_SER_FIFO_ADDR) begin
					if (rx == 0)
						first_tx = i_bus.wdata;
					rx++;
				end else if (i_bus.addr == `SEBL_DCTL_ADDR) begin
					ctl.push_back(i_bus.wdata[`SEBL_DCTL_I_MSB:`SEBL_DCTL_I_LSB]);
				end else if (i_bus.addr[31:8] == 24'hA07001) begin
					mc[i_bus.addr[6:2]] = i_bus.wdata;
				end else begin
					mem[i_bus.addr[6:2]] = i_bus.wdata;
					memw++;
				end
			end else if (i_bus.addr == `SEBL_SER_STAT_ADDR) begin
				st = '0;
				st[`SEBL_RX_WORD_READY_BIT] = rx > rd;
				st[`SEBL_RX_FIFO_BYTE_COUNT_MSB:`SEBL_RX_FIFO_BYTE_COUNT_LSB] =
					(rx > rd) ? `SEBL_RX_FIFO_BYTE_COUNT_FULL : 2'h1;
				o_rdata <= st;
			end else if (i_bus.addr == `SEBL_SER_FIFO_ADDR) begin
				o_rdata <= img[rd];
				rd++;
			end else if (i_bus.addr == `SEBL_DCFG0_ADDR) begin
				o_rdata <= mc[0];
			end else begin
				mode_addr = i_bus.addr;
			end
		end
	end
endmodule : sebl_bus_model

// *** dv/sebl_loader_tb_top.sv ***
`timescale 1ns/1ps
`include "sebl_cfg.svh"
module sebl_loader_tb_top;
	import sebl_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic pen = 1'b0;
	logic pwr = 1'b0;
	logic [1:0] cfg = 2'h3;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] x = 32'hFCDD_BB86;
	logic [31:0] prdata, rdata, q, w;
	logic cpu_rst, ser_rst, done, pready, pslverr, ack, e;
	sebl_bus_req_t bus;
	int errors = 0;
	int checks_done = 0;
	int nc, total, k;
	always #5 clk = ~clk;
	sebl_loader i_sebl_loader (.I_CORE_CLK(clk), .I_RST(rst), .I_BOOT_CFG(cfg),
		.O_CPU_RST(cpu_rst), .O_SER_RST(ser_rst), .O_BOOT_DONE(done), .O_BUS(bus),
		.I_BUS_ACK(ack), .I_BUS_RDATA(rdata), .I_PSEL(psel), .I_PENABLE(pen),
		.I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
		.O_PREADY(pready), .O_PSLVERR(pslverr));
	sebl_bus_model i_sebl_bus_model (.i_clk(clk), .i_rst(rst), .i_bus(bus), .o_ack(ack),
		.o_rdata(rdata));
	function automatic logic [31:0] rnd();
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		x = x ^ (x << 5);
		return x;
	endfunction : rnd
	// done set, booting clear, word counter in the upper half
	function automatic logic [31:0] exp_status(input int t);
		return {t[15:0], 16'h0001};
	endfunction : exp_status
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwr <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1)
			@(posedge clk);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
		@(posedge clk);
	endtask : apb
	task automatic start(input logic [1:0] c);
		rst <= 1'b1;
		cfg <= c;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
	endtask : start
	task automatic report_and_stop();
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : report_and_stop
	initial begin
		repeat (30000) @(posedge clk);
		errors++;
		report_and_stop();
	end
	initial begin
		@(posedge clk);
		start(2'h1);
		repeat (10) @(posedge clk);
		chk(32'(cpu_rst), 32'h0);
		chk(i_sebl_bus_model.ops, 0);
		$display("bypass test done");
		// second boot uses the shortest legal image
		for (int b = 0; b < 2; b++) begin
			nc = b ? 0 : rnd() % 8 + 1;
			total = 33 + nc;
			for (k = 0; k < 64; k++)
				i_sebl_bus_model.img[k] = rnd();
			// command echo and pad fill exactly the first word, which is thrown away
			i_sebl_bus_model.img[0] = 32'hFFFF_FFFF;
			i_sebl_bus_model.img[1] = total;
			i_sebl_bus_model.img[2] = (rnd() & 32'h0FFF) << 12;
			i_sebl_bus_model.img[3][`SEBL_BUF_BIT] = 1'b0;
			start(2'h3);
			for (k = 0; k < 8000 && done !== 1'b1; k++)
				@(posedge clk);
			chk(32'(done), 32'h1);
			repeat (2) @(posedge clk);
			chk(32'(cpu_rst), 32'h0);
			chk(32'(ser_rst), 32'h1);
			chk(i_sebl_bus_model.first_tx, `SEBL_CMD_RST);
			chk(i_sebl_bus_model.mode_addr, i_sebl_bus_model.img[2]);
			chk(i_sebl_bus_model.ctl.size(), 3);
			for (k = 0; k < 3; k++)
				chk(32'(i_sebl_bus_model.ctl[k]), 32'(2 - k));
			w = i_sebl_bus_model.img[3] | (32'h1 << `SEBL_BUF_BIT);
			chk(i_sebl_bus_model.mc[0], w);
			for (k = 1; k < 17; k++)
				chk(i_sebl_bus_model.mc[k], i_sebl_bus_model.img[k + 3]);
			for (k = 0; k < nc; k++)
				chk(i_sebl_bus_model.mem[k], i_sebl_bus_model.img[k + 33]);
			chk(i_sebl_bus_model.memw, nc);
			$display("boot test %0d done", b);
		end
		for (k = 0; k < 2; k++) begin
			apb(1'b0, 12'(k * 4), 32'h0);
			chk(q, k ? `SEBL_NOP_RST : `SEBL_CMD_RST);
			w = rnd();
			apb(1'b1, 12'(k * 4), w);
			apb(1'b0, 12'(k * 4), 32'h0);
			chk(q, w);
		end
		// read-only and unmapped places: writes must not stick
		for (k = 8; k < 17; k += 4) begin
			apb(1'b1, 12'(k), rnd());
			apb(1'b0, 12'(k), 32'h0);
			chk(q, k == 8 ? exp_status(total) : k == 12 ? 32'(total) : 32'h0);
			chk(32'(e), 32'(k == 16));
		end
		$display("register test done");
		report_and_stop();
	end
endmodule : sebl_loader_tb_top
